/* File: rtl/pmpctl_pkg.sv */
// Package of constants for the pump level controller.
// Assumes a single 100 MHz system clock domain.
package pmpctl_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned LEVEL_W = 16;
  localparam int unsigned NUM_EVENTS = 8;
  localparam int unsigned NUM_INPUTS = 8;
  localparam int unsigned NUM_ANALOG = 8;
  localparam int unsigned NUM_OUTPUTS = 2;
  // Pump method encoding.
  localparam logic [1:0] METHOD_DRAIN_ANALOG = 2'h0;
  localparam logic [1:0] METHOD_DRAIN_FLOAT = 2'h1;
  localparam logic [1:0] METHOD_FILL_ANALOG = 2'h2;
  localparam logic [1:0] METHOD_FILL_FLOAT = 2'h3;
  // Output mode encoding.
  localparam logic [1:0] OMODE_MANUAL = 2'h0;
  localparam logic [1:0] OMODE_ALARM = 2'h1;
  localparam logic [1:0] OMODE_PUMP = 2'h2;
  // Event comparison encoding.
  localparam logic [1:0] CMP_GREATER = 2'h0;
  localparam logic [1:0] CMP_LESS = 2'h1;
  localparam logic [1:0] CMP_EQUAL = 2'h2;
  // Dedicated float inputs (zero based contact index 5..7) and the analog level channel.
  localparam int unsigned LEAD_INPUT = 5;
  localparam int unsigned LAG_INPUT = 6;
  localparam int unsigned OFF_INPUT = 7;
  localparam int unsigned LEVEL_INPUT = 5;
  // Reset values.
  localparam logic RST_LEAD_SEL = 1'h0;
  localparam logic [1:0] RST_STATE = 2'h0;
endpackage : pmpctl_pkg

/* File: rtl/pmpctl_sync.sv */
// Three-stage synchroniser for pin inputs with agreement filter.
// Assumes CLK_SYS domain and synchronous active-low reset.
`timescale 1ns/10ps
module pmpctl_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  // A change counts only once the second and third stages agree.
  always_comb begin
    level_d = level_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        level_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;
endmodule : pmpctl_sync

/* File: rtl/pmpctl_top.sv */
// Pump level controller: simplex/duplex fill or drain pump control from
// floats or an analog level, plus a small table of output events.
// Assumes float contacts are normally open pins, analog levels arrive as
// already-sampled words on CLK_SYS, and software drives the plain ports.
//
// Behaviour
// [RL1] Drain float: lead float closing starts lead pump.
// [RL2] Drain float: lag float closing adds second pump.
// [RL3] Drain: below pumps-off float, both pumps stop.
// [RL4] Stuck float runs both pumps, alarms pump outputs.
// [RL5] Duplex alternates lead pump between pumping cycles.
// [RL6] Simplex on either single pump output, lead/off.
// [RL7] Fill float: level below lead starts pump.
// [RL8] Fill: level above pumps-off stops running pump.
// [RL9] Fill: below lag adds pump until off closes.
// [RL10] Analog mode compares input six with levels.
// [RL11] Analog: duplex with two outputs, else simplex.
// [RL12] Four pump methods: drain/fill, analog/float.
// [RL13] Programmed levels ignored in float methods.
// [RL14] Pump logic acts only on pump-mode outputs.
// [RL15] Up to eight compare-and-switch output events.
// [RL16] Events affect only manual-mode outputs.
// [RL17] Events set on becoming true, never revert.
// [RL18] Floats are normally open; closed means liquid.
// [RL19] Analog thresholds act as equivalent float closures.
// [RL20] Duplex: lead swaps on each entry to all-off.
`timescale 1ns/10ps
module pmpctl_top #(
  parameter int unsigned LEVEL_W = pmpctl_pkg::LEVEL_W,
  parameter int unsigned NUM_EVENTS = pmpctl_pkg::NUM_EVENTS
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Dry contact pins, closed is high.
  input wire logic [pmpctl_pkg::NUM_INPUTS-1:0] CONTACT_IN,
  // Analog levels, signed, one word per channel.
  input wire logic [pmpctl_pkg::NUM_ANALOG*LEVEL_W-1:0] ANALOG_IN,
  // Pump configuration.
  input wire logic [1:0] PUMP_METHOD,
  input wire logic [LEVEL_W-1:0] LEAD_LEVEL,
  input wire logic [LEVEL_W-1:0] LAG_LEVEL,
  input wire logic [LEVEL_W-1:0] OFF_LEVEL,
  input wire logic [pmpctl_pkg::NUM_OUTPUTS*2-1:0] OUT_MODE,
  // Manual set and alarm-mode drive for each output.
  input wire logic [pmpctl_pkg::NUM_OUTPUTS-1:0] MANUAL_WR,
  input wire logic [pmpctl_pkg::NUM_OUTPUTS-1:0] MANUAL_VAL,
  input wire logic [pmpctl_pkg::NUM_OUTPUTS-1:0] ALARM_DRIVE,
  // Event table: enable, input select, analog flag, compare, value, target.
  input wire logic [NUM_EVENTS-1:0] EV_ENABLE,
  input wire logic [NUM_EVENTS*3-1:0] EV_INPUT_SEL,
  input wire logic [NUM_EVENTS-1:0] EV_IS_ANALOG,
  input wire logic [NUM_EVENTS*2-1:0] EV_COMPARE,
  input wire logic [NUM_EVENTS*LEVEL_W-1:0] EV_VALUE,
  input wire logic [NUM_EVENTS-1:0] EV_REMOTE,
  input wire logic [NUM_EVENTS-1:0] EV_TARGET,
  input wire logic [NUM_EVENTS-1:0] EV_SET_VAL,
  // Remote output events: one-cycle strobe, target and value held until the next one.
  output logic REMOTE_EVENT_STB,
  output logic REMOTE_EVENT_TARGET,
  output logic REMOTE_EVENT_VAL,
  // Relay drives and status.
  output logic [pmpctl_pkg::NUM_OUTPUTS-1:0] RELAY_OUT,
  output logic [pmpctl_pkg::NUM_OUTPUTS-1:0] PUMP_ALARM,
  output logic LEAD_SEL
);
  typedef enum logic [1:0] {
    PMPCTL_IDLE,
    PMPCTL_LEAD,
    PMPCTL_BOTH
  } pmpctl_state_e;

  logic [pmpctl_pkg::NUM_INPUTS-1:0] contact;
  logic [pmpctl_pkg::NUM_OUTPUTS-1:0] is_pump;
  logic [pmpctl_pkg::NUM_OUTPUTS-1:0] is_manual;
  logic analog_mode;
  logic fill_mode;
  logic duplex;
  logic simplex_out;
  logic [LEVEL_W-1:0] level;
  logic lead_cl;
  logic lag_cl;
  logic off_cl;
  logic stuck;
  logic want_lead;
  logic want_lag;
  logic want_stop;
  pmpctl_state_e state_q;
  pmpctl_state_e state_d;
  logic lead_sel_q;
  logic lead_sel_d;
  logic [pmpctl_pkg::NUM_OUTPUTS-1:0] pump_on;
  logic [pmpctl_pkg::NUM_OUTPUTS-1:0] relay_q;
  logic [pmpctl_pkg::NUM_OUTPUTS-1:0] relay_d;
  logic [pmpctl_pkg::NUM_OUTPUTS-1:0] alarm_q;
  logic [pmpctl_pkg::NUM_OUTPUTS-1:0] alarm_d;
  logic [NUM_EVENTS-1:0] cond;
  logic [NUM_EVENTS-1:0] cond_q;
  logic [NUM_EVENTS-1:0] fire;
  logic rem_stb_q;
  logic rem_stb_d;
  logic rem_tgt_q;
  logic rem_tgt_d;
  logic rem_val_q;
  logic rem_val_d;

  // Signed comparison used by both the level thresholds and the events.
  function automatic logic sge(input logic [LEVEL_W-1:0] a,
                               input logic [LEVEL_W-1:0] b);
    sge = $signed(a) >= $signed(b);
  endfunction : sge

  function automatic logic [LEVEL_W-1:0] analog_word(
      input logic [pmpctl_pkg::NUM_ANALOG*LEVEL_W-1:0] bus,
      input logic [2:0] idx);
    analog_word = bus[idx*LEVEL_W +: LEVEL_W];
  endfunction : analog_word

  pmpctl_sync #(
    .WIDTH(pmpctl_pkg::NUM_INPUTS)
  ) u_sync (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .pin(CONTACT_IN),
    .level(contact)
  );

  genvar g;
  generate
    for (g = 0; g < pmpctl_pkg::NUM_OUTPUTS; g++) begin : g_mode
      assign is_pump[g] =
        OUT_MODE[g*2 +: 2] == pmpctl_pkg::OMODE_PUMP; // see [RL14]
      assign is_manual[g] =
        OUT_MODE[g*2 +: 2] == pmpctl_pkg::OMODE_MANUAL; // see [RL16]
    end
  endgenerate

  // Method decode; bit 0 clear means analog, bit 1 set means fill.
  assign analog_mode = !PUMP_METHOD[0]; // see [RL12]
  assign fill_mode = PUMP_METHOD[1]; // see [RL12]
  assign duplex = &is_pump; // see [RL11]
  assign simplex_out = is_pump[1] & ~is_pump[0]; // see [RL6]
  assign level = analog_word(ANALOG_IN,
                             3'(pmpctl_pkg::LEVEL_INPUT)); // see [RL10]

  // Equivalent float closures; closed means liquid at that float.
  // Drain thresholds close at or above, fill thresholds also close when
  // liquid reaches them, so the same sense holds for both methods.
  always_comb begin
    if (analog_mode) begin
      lead_cl = sge(level, LEAD_LEVEL); // see [RL19]
      lag_cl = duplex & sge(level, LAG_LEVEL); // see [RL19]
      off_cl = sge(level, OFF_LEVEL); // see [RL10]
    end else begin
      // Programmed levels play no part here.
      lead_cl = contact[pmpctl_pkg::LEAD_INPUT]; // see [RL13] [RL18]
      lag_cl = duplex & contact[pmpctl_pkg::LAG_INPUT]; // see [RL6]
      off_cl = contact[pmpctl_pkg::OFF_INPUT];
    end
  end

  // Drain: floats above the off float should never close while it is
  // open. Fill: floats below the off float cannot open while it is closed.
  always_comb begin
    if (fill_mode) begin
      stuck = off_cl & (~lead_cl | (duplex & ~lag_cl)); // see [RL4]
      want_lead = ~lead_cl; // see [RL7]
      want_lag = duplex & ~lag_cl; // see [RL9]
      want_stop = off_cl; // see [RL8] [RL9]
    end else begin
      stuck = ~off_cl & (lead_cl | lag_cl); // see [RL4]
      want_lead = lead_cl; // see [RL1]
      want_lag = lag_cl; // see [RL2]
      want_stop = ~off_cl; // see [RL3]
    end
  end

  always_comb begin
    state_d = state_q;
    lead_sel_d = lead_sel_q;
    case (state_q)
      PMPCTL_IDLE: begin
        if (want_lag || stuck) begin
          state_d = PMPCTL_BOTH;
        end else if (want_lead && !want_stop) begin
          state_d = PMPCTL_LEAD; // see [RL1] [RL7]
        end
      end
      PMPCTL_LEAD: begin
        if (want_lag || stuck) begin
          state_d = PMPCTL_BOTH; // see [RL2] [RL9]
        end else if (want_stop) begin
          state_d = PMPCTL_IDLE; // see [RL3] [RL8]
        end
      end
      PMPCTL_BOTH: begin
        if (want_stop && !stuck) begin
          state_d = PMPCTL_IDLE; // see [RL3] [RL9]
        end
      end
      default: begin
        state_d = PMPCTL_IDLE;
      end
    endcase
    if (state_q != PMPCTL_IDLE && state_d == PMPCTL_IDLE && duplex) begin
      lead_sel_d = ~lead_sel_q; // see [RL5] [RL20]
    end
    if (~|is_pump) begin
      state_d = PMPCTL_IDLE; // see [RL14]
    end
  end

  // Map the state onto physical outputs.
  always_comb begin
    pump_on = '0;
    if (duplex) begin
      if (state_q == PMPCTL_BOTH) begin
        pump_on = 2'h3;
      end else if (state_q == PMPCTL_LEAD) begin
        pump_on[lead_sel_q] = 1'b1; // see [RL5]
      end
    end else if (state_q != PMPCTL_IDLE) begin
      pump_on[simplex_out] = 1'b1; // see [RL6]
    end
    pump_on = pump_on & is_pump; // see [RL14]
  end

  // Event conditions.
  generate
    for (g = 0; g < NUM_EVENTS; g++) begin : g_cond
      logic [LEVEL_W-1:0] lhs;
      logic [LEVEL_W-1:0] rhs;
      assign lhs = EV_IS_ANALOG[g]
        ? analog_word(ANALOG_IN, EV_INPUT_SEL[g*3 +: 3])
        : {{(LEVEL_W-1){1'b0}}, contact[EV_INPUT_SEL[g*3 +: 3]]};
      assign rhs = EV_VALUE[g*LEVEL_W +: LEVEL_W];
      always_comb begin
        case (EV_COMPARE[g*2 +: 2])
          pmpctl_pkg::CMP_GREATER: cond[g] = EV_ENABLE[g] & !sge(rhs, lhs);
          pmpctl_pkg::CMP_LESS: cond[g] = EV_ENABLE[g] & !sge(lhs, rhs);
          pmpctl_pkg::CMP_EQUAL: cond[g] = EV_ENABLE[g] & (lhs == rhs);
          default: cond[g] = 1'b0;
        endcase
      end
    end
  endgenerate
  assign fire = cond & ~cond_q; // see [RL15] [RL17]

  // Relays, alarms and remote events; lower event index wins.
  always_comb begin
    relay_d = relay_q;
    alarm_d = '0;
    rem_stb_d = 1'b0;
    rem_tgt_d = rem_tgt_q;
    rem_val_d = rem_val_q;
    for (int o = 0; o < pmpctl_pkg::NUM_OUTPUTS; o++) begin
      if (is_manual[o] && MANUAL_WR[o]) begin
        relay_d[o] = MANUAL_VAL[o];
      end
    end
    for (int e = NUM_EVENTS - 1; e >= 0; e--) begin
      if (fire[e] && !EV_REMOTE[e] && is_manual[EV_TARGET[e]]) begin
        relay_d[EV_TARGET[e]] = EV_SET_VAL[e]; // see [RL16] [RL17]
      end
      if (fire[e] && EV_REMOTE[e]) begin
        rem_stb_d = 1'b1; // see [RL15]
        rem_tgt_d = EV_TARGET[e];
        rem_val_d = EV_SET_VAL[e];
      end
    end
    for (int o = 0; o < pmpctl_pkg::NUM_OUTPUTS; o++) begin
      if (is_pump[o]) begin
        relay_d[o] = pump_on[o]; // see [RL14]
        alarm_d[o] = stuck; // see [RL4]
      end else if (!is_manual[o]) begin
        relay_d[o] = ALARM_DRIVE[o];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_q <= PMPCTL_IDLE;
      lead_sel_q <= pmpctl_pkg::RST_LEAD_SEL;
      relay_q <= pmpctl_pkg::RST_STATE;
      alarm_q <= pmpctl_pkg::RST_STATE;
      cond_q <= '0;
      rem_stb_q <= 1'b0;
      rem_tgt_q <= 1'b0;
      rem_val_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lead_sel_q <= lead_sel_d;
      relay_q <= relay_d;
      alarm_q <= alarm_d;
      cond_q <= cond;
      rem_stb_q <= rem_stb_d;
      rem_tgt_q <= rem_tgt_d;
      rem_val_q <= rem_val_d;
    end
  end

  assign RELAY_OUT = relay_q;
  assign PUMP_ALARM = alarm_q;
  assign LEAD_SEL = lead_sel_q;
  assign REMOTE_EVENT_STB = rem_stb_q;
  assign REMOTE_EVENT_TARGET = rem_tgt_q;
  assign REMOTE_EVENT_VAL = rem_val_q;
endmodule : pmpctl_top

/* File: testbench/pmpctl_well.sv */
// Well model: float contacts and the level sensor word for the controller.
// Assumes the bench sets the level, the application and any stuck float.
`timescale 1ns/10ps
module pmpctl_well (
  // Level, second analog channel, application and fault.
  input wire logic signed [15:0] lvl,
  input wire logic signed [15:0] aux,
  input wire logic fill,
  input wire logic stuck,
  // Sensor outputs.
  output logic [7:0] contacts,
  output logic [127:0] analog
);
  // A float closes once liquid reaches it; fill swaps lag and off heights.
  always_comb begin
    contacts = 8'h00;
    contacts[5] = (lvl >= 16'sh00C8) || stuck;
    contacts[6] = lvl >= (fill ? 16'sh0064 : 16'sh012C);
    contacts[7] = lvl >= (fill ? 16'sh012C : 16'sh0064);
    analog = 128'h0;
    analog[80+:16] = lvl;
    analog[15:0] = aux;
  end
endmodule : pmpctl_well

/* File: testbench/pmpctl_chk.sv */
// Assertion checker for the pump level controller top ports.
// Assumes it is bound onto pmpctl_top, one clock domain on CLK_SYS.
`timescale 1ns/10ps
module pmpctl_chk #(
  parameter int unsigned LEVEL_W = 16,
  parameter int unsigned NUM_EVENTS = 8
) (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic NRST,
  // Watched inputs.
  input wire logic [pmpctl_pkg::NUM_ANALOG*LEVEL_W-1:0] ANALOG_IN,
  input wire logic [1:0] PUMP_METHOD,
  input wire logic [LEVEL_W-1:0] LEAD_LEVEL,
  input wire logic [LEVEL_W-1:0] LAG_LEVEL,
  input wire logic [LEVEL_W-1:0] OFF_LEVEL,
  input wire logic [3:0] OUT_MODE,
  input wire logic [NUM_EVENTS-1:0] EV_ENABLE,
  input wire logic [NUM_EVENTS-1:0] EV_REMOTE,
  // Watched outputs.
  input wire logic REMOTE_EVENT_STB,
  input wire logic [1:0] RELAY_OUT,
  input wire logic [1:0] PUMP_ALARM,
  input wire logic LEAD_SEL
);
  logic signed [LEVEL_W-1:0] lv;
  logic ge_ld, ge_lg, ge_of, da, fa, duo, rem_en;
  logic [1:0] pm;
  assign lv = ANALOG_IN[5*LEVEL_W+:LEVEL_W];
  assign ge_ld = lv >= $signed(LEAD_LEVEL);
  assign ge_lg = lv >= $signed(LAG_LEVEL);
  assign ge_of = lv >= $signed(OFF_LEVEL);
  assign da = PUMP_METHOD == pmpctl_pkg::METHOD_DRAIN_ANALOG;
  assign fa = PUMP_METHOD == pmpctl_pkg::METHOD_FILL_ANALOG;
  assign pm[0] = OUT_MODE[1:0] == pmpctl_pkg::OMODE_PUMP;
  assign pm[1] = OUT_MODE[3:2] == pmpctl_pkg::OMODE_PUMP;
  assign duo = &pm;
  assign rem_en = |(EV_ENABLE & EV_REMOTE);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // The analog path needs a few edges to pass through state and relay.
  sequence s_hold(c);
    c [*5];
  endsequence
  AST_DRAIN_BOTH: assert property (
    s_hold(da && duo && ge_ld && ge_lg && ge_of) |-> RELAY_OUT == 2'h3)
    else $error("drain high not both pumps");
  AST_DRAIN_IDLE: assert property (
    s_hold(da && duo && !ge_ld && !ge_of) |-> RELAY_OUT == 2'h0)
    else $error("drain low pumps still on");
  AST_DRAIN_STUCK: assert property (
    s_hold(da && duo && ge_ld && !ge_of)
    |-> PUMP_ALARM == 2'h3 && RELAY_OUT == 2'h3)
    else $error("stuck level without alarm");
  AST_FILL_FULL: assert property (
    s_hold(fa && duo && ge_ld && ge_lg && ge_of) |-> RELAY_OUT == 2'h0)
    else $error("full well pumps on");
  AST_FILL_LOW: assert property (
    s_hold(fa && duo && !ge_ld && !ge_lg && !ge_of) |-> RELAY_OUT == 2'h3)
    else $error("empty well not both");
  AST_SIMPLEX: assert property (
    s_hold(da && OUT_MODE == 4'h2 && ge_ld && ge_of) |-> RELAY_OUT[0])
    else $error("simplex pump not on");
  AST_LEAD_SWAP: assert property (
    $changed(LEAD_SEL) |=> RELAY_OUT == 2'h0)
    else $error("lead swapped while pumping");
  AST_ALARM_MASK: assert property (
    s_hold($stable(OUT_MODE)) |-> (PUMP_ALARM & ~pm) == 2'h0)
    else $error("alarm on non pump");
  AST_REMOTE_CAUSE: assert property (
    REMOTE_EVENT_STB |-> $past(rem_en))
    else $error("remote event without enable");
endmodule : pmpctl_chk

bind pmpctl_top pmpctl_chk #(.LEVEL_W(LEVEL_W), .NUM_EVENTS(NUM_EVENTS)) i_chk (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .ANALOG_IN(ANALOG_IN),
  .PUMP_METHOD(PUMP_METHOD), .LEAD_LEVEL(LEAD_LEVEL), .LAG_LEVEL(LAG_LEVEL),
  .OFF_LEVEL(OFF_LEVEL), .OUT_MODE(OUT_MODE), .EV_ENABLE(EV_ENABLE),
  .EV_REMOTE(EV_REMOTE), .REMOTE_EVENT_STB(REMOTE_EVENT_STB),
  .RELAY_OUT(RELAY_OUT), .PUMP_ALARM(PUMP_ALARM), .LEAD_SEL(LEAD_SEL)
);

/* File: testbench/testbench.sv */
// Self-checking bench for the pump level controller.
// Assumes the well model feeds the sensor ports; inputs change at negedge.
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [1:0] m;
    logic [3:0] om;
    logic signed [15:0] lv;
    logic signed [15:0] off;
    logic signed [15:0] lag;
    logic [1:0] exp;
  } pmpctl_row_s;
  localparam logic [1:0] da = pmpctl_pkg::METHOD_DRAIN_ANALOG;
  localparam logic [1:0] df = pmpctl_pkg::METHOD_DRAIN_FLOAT;
  localparam logic [1:0] fa = pmpctl_pkg::METHOD_FILL_ANALOG;
  localparam logic [1:0] ff = pmpctl_pkg::METHOD_FILL_FLOAT;
  localparam logic signed [15:0] l50 = 16'sh0032, l150 = 16'sh0096;
  localparam logic signed [15:0] l250 = 16'sh00FA, l350 = 16'sh015E;
  localparam logic signed [15:0] t100 = 16'sh0064, t300 = 16'sh012C;
  localparam logic signed [15:0] nf = 16'sh7FFF;
  // Order matters: the lead pump swaps each time a duplex cycle ends.
  localparam pmpctl_row_s rows [22] = '{
    '{da, 4'hA, l150, t100, t300, 2'h0}, '{da, 4'hA, l250, t100, t300, 2'h1},
    '{da, 4'hA, l350, t100, t300, 2'h3}, '{da, 4'hA, l50, t100, t300, 2'h0},
    '{da, 4'hA, l250, t100, t300, 2'h2}, '{da, 4'hA, l50, t100, t300, 2'h0},
    '{da, 4'h2, l350, t100, t300, 2'h1}, '{da, 4'h2, l50, t100, t300, 2'h0},
    '{da, 4'h8, l350, t100, t300, 2'h2}, '{da, 4'h8, l50, t100, t300, 2'h0},
    '{df, 4'hA, l250, nf, nf, 2'h1}, '{df, 4'hA, l350, nf, nf, 2'h3},
    '{df, 4'hA, l50, nf, nf, 2'h0}, '{fa, 4'hA, l350, t300, t100, 2'h0},
    '{fa, 4'hA, l150, t300, t100, 2'h2}, '{fa, 4'hA, l50, t300, t100, 2'h3},
    '{fa, 4'hA, l250, t300, t100, 2'h3}, '{fa, 4'hA, l350, t300, t100, 2'h0},
    '{ff, 4'hA, l350, nf, nf, 2'h0}, '{ff, 4'hA, l150, nf, nf, 2'h1},
    '{ff, 4'hA, l350, nf, nf, 2'h0}, '{ff, 4'h5, l350, nf, nf, 2'h2}};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] method = da;
  logic [3:0] out_mode = 4'hA;
  logic [15:0] lead_lv = 16'h00C8, lag_lv = 16'h012C, off_lv = 16'h0064;
  logic signed [15:0] lvl = l50, aux = 16'sh001E;
  logic stuck = 1'b0;
  logic [7:0] ev_en = 8'h00;
  logic [1:0] alarm_drv = 2'h2;
  logic [7:0] ev_rem = 8'h08, ev_set = 8'h0D;
  logic [1:0] man_wr = 2'h0, man_val = 2'h0;
  logic [7:0] contacts;
  logic [127:0] analog;
  logic stb, tgt, val, lead_sel;
  logic [1:0] relay, alarm;
  int fail_count = 0, samples_checked = 0;
  always #5 clk_sys = ~clk_sys;
  pmpctl_well i_well (.lvl(lvl), .aux(aux), .fill(method[1]), .stuck(stuck),
    .contacts(contacts), .analog(analog));
  pmpctl_top i_dut (.CLK_SYS(clk_sys), .NRST(rst_n), .CONTACT_IN(contacts),
    .ANALOG_IN(analog), .PUMP_METHOD(method), .LEAD_LEVEL(lead_lv),
    .LAG_LEVEL(lag_lv), .OFF_LEVEL(off_lv), .OUT_MODE(out_mode),
    .MANUAL_WR(man_wr), .MANUAL_VAL(man_val), .ALARM_DRIVE(alarm_drv),
    .EV_ENABLE(ev_en), .EV_INPUT_SEL(24'h000000), .EV_IS_ANALOG(8'h0F),
    .EV_COMPARE({8'h00, pmpctl_pkg::CMP_EQUAL, pmpctl_pkg::CMP_GREATER,
      pmpctl_pkg::CMP_LESS, pmpctl_pkg::CMP_GREATER}),
    .EV_VALUE({64'h0, 64'h0046_003C_0014_003C}), .EV_REMOTE(ev_rem),
    .EV_TARGET(8'h0C), .EV_SET_VAL(ev_set), .REMOTE_EVENT_STB(stb),
    .REMOTE_EVENT_TARGET(tgt), .REMOTE_EVENT_VAL(val), .RELAY_OUT(relay),
    .PUMP_ALARM(alarm), .LEAD_SEL(lead_sel));

  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  task automatic run_row(input pmpctl_row_s r);
    method = r.m;
    out_mode = r.om;
    lvl = r.lv;
    off_lv = r.off;
    lag_lv = r.lag;
    lead_lv = r.m[0] ? nf : 16'sh00C8;
    repeat (8) @(negedge clk_sys);
    chk({6'h00, relay}, {6'h00, r.exp});
  endtask : run_row

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  initial begin
    int i;
    repeat (8) @(negedge clk_sys);
    chk({2'h0, relay, alarm, lead_sel, stb}, 8'h00);
    $display("reset test done");
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    foreach (rows[k]) begin
      run_row(rows[k]);
    end
    chk({7'h00, lead_sel}, 8'h01);
    alarm_drv = 2'h1;
    repeat (2) @(negedge clk_sys);
    chk({6'h00, relay}, 8'h01);
    $display("table rows done");
    run_row('{da, 4'hA, 16'sh00E1, 16'sh00FA, t300, 2'h3});
    chk({6'h00, alarm}, 8'h03);
    stuck = 1'b1;
    run_row('{df, 4'hA, l50, nf, nf, 2'h3});
    chk({6'h00, alarm}, 8'h03);
    stuck = 1'b0;
    run_row('{df, 4'hA, l50, nf, nf, 2'h0});
    chk({6'h00, alarm}, 8'h00);
    $display("stuck float test done");
    run_row('{da, 4'h8, l50, t100, t300, 2'h0});
    ev_en = 8'h0F;
    aux = 16'sh0046;
    for (i = 0; i < 10 && stb !== 1'b1; i++) @(negedge clk_sys);
    chk({5'h00, stb, tgt, val}, 8'h07);
    if (stb !== 1'b1) close_out();
    repeat (2) @(negedge clk_sys);
    chk({6'h00, relay}, 8'h01);
    aux = l50;
    repeat (4) @(negedge clk_sys);
    chk({6'h00, relay}, 8'h01);
    aux = 16'sh000A;
    repeat (4) @(negedge clk_sys);
    chk({6'h00, relay}, 8'h00);
    man_val = 2'h3;
    man_wr = 2'h3;
    @(negedge clk_sys);
    man_wr = 2'h0;
    repeat (2) @(negedge clk_sys);
    chk({6'h00, relay}, 8'h01);
    $display("event test done");
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk({2'h0, relay, alarm, lead_sel, stb}, 8'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({2'h0, relay, alarm, lead_sel, stb}, 8'h00);
    $display("mid-run reset test done");
    close_out();
  end
endmodule : testbench
